// ===== logic/scmc_cfg.svh
// Constants of the standby and clock mode controller
`ifndef SCMC_CFG_SVH
`define SCMC_CFG_SVH
// =============================================================
// Control word field positions
`define SCMC_CTL_W 5
`define SCMC_CTL_XEN 4
`define SCMC_CTL_XTEN 3
`define SCMC_CTL_SYSCK 2
`define SCMC_CTL_IDLE 1
`define SCMC_CTL_TIMING_GEN_HALT_BIT 0
// =============================================================
// Base timer source select
`define SCMC_TBT_SEL_W 3
`define SCMC_TBT_TAPS 8
// =============================================================
// Timing
`define SCMC_CLK_NS 10
`define SCMC_GAP_NS 20
`define SCMC_GAP_CYC ((`SCMC_GAP_NS + `SCMC_CLK_NS - 1) / `SCMC_CLK_NS)
`define SCMC_GAP_W 2
// Nominal sub clock resonator, in Hz
`define SCMC_SUB_CLOCK_HZ 32768
`endif

// ===== logic/scmc_pkg.sv
// Types of the standby and clock mode controller
package scmc_pkg;
   // ==========================================================
   // Operating modes
   typedef enum logic [3:0] {
      single_clock_run_mode,
      dual_clock_run_mode,
      slow_main_osc_on_mode,
      slow_main_osc_off_mode,
      cpu_halt_hf_mode,
      cpu_halt_dual_mode,
      deep_idle_hf_mode,
      cpu_halt_lf_mode,
      cpu_halt_lf_dual_mode,
      deep_idle_lf_mode,
      osc_stop_mode
   } scmc_mode_t;
   // ==========================================================
   // Clock enables handed to the chip
   typedef struct packed {
      logic main_osc_en;
      logic sub_osc_en;
      logic cpu_clk_en;
      logic cpu_clk_sel_lf;
      logic periph_hf_en;
      logic periph_lf_en;
      logic tbt_clk_en;
      logic tbt_clk_sel_lf;
   } scmc_clk_ctrl_t;
endpackage : scmc_pkg

// ===== logic/scmc_sync.sv
// Pin input synchroniser with agreement filter
`timescale 1ns/100ps
module scmc_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // =================================================
         // Three stages; stage one feeds stage two only
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               s1_ff[g] <= 1'b0;
               s2_ff[g] <= 1'b0;
               s3_ff[g] <= 1'b0;
               level_o[g] <= 1'b0;
            end else begin
               s1_ff[g] <= pin_i[g];
               s2_ff[g] <= s1_ff[g];
               s3_ff[g] <= s2_ff[g];
               if (s2_ff[g] == s3_ff[g]) begin
                  level_o[g] <= s3_ff[g];
               end
            end
         end
      end
   endgenerate
endmodule : scmc_sync

// ===== logic/scmc_top.sv
// Standby and clock-source mode controller
// What this block does
// - Stop mode halts both oscillators and clocks
// - Slow one: low clock, main oscillator off
// - Slow two: CPU low clock, main running
// - Deep idle high: timer only, wakes on edge
// - Deep idle low: timer on low clock, edge
// - Idle high: CPU halted, interrupt wakes
// - Idle dual: CPU halted, both clocks, interrupt
// - Sleep one: CPU halted, low clock, interrupt
// - Sleep two: CPU halted, both oscillators, interrupt
// - Two independent oscillators, main and sub
// - Stop release input ends stop mode
// - Reset enters single clock run mode
// - Idle bit write enters an idle or sleep mode
// - Halt bit write enters a deep idle
`timescale 1ns/100ps
`include "scmc_cfg.svh"
module scmc_top (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ctl_wr_i,
   input wire logic [`SCMC_CTL_W-1:0] ctl_data_i,
   input wire logic stop_req_i,
   input wire logic stop_release_i,
   input wire logic irq_req_i,
   input wire logic [`SCMC_TBT_SEL_W-1:0] base_timer_clock_select_i,
   input wire logic [`SCMC_TBT_TAPS-1:0] tbt_src_i,
   output scmc_pkg::scmc_mode_t mode_o,
   output scmc_pkg::scmc_clk_ctrl_t clk_ctrl_o,
   output logic wake_o
);
   scmc_pkg::scmc_mode_t mode_ff;
   scmc_pkg::scmc_mode_t nxt_mode;
   scmc_pkg::scmc_mode_t resume_ff;
   scmc_pkg::scmc_clk_ctrl_t nxt_ctrl;
   logic stop_rel_lvl;
   logic tap_prev_ff;
   logic tap_fall;
   logic wake;
   logic [`SCMC_GAP_W-1:0] gap_ff;
   logic [`SCMC_GAP_W-1:0] nxt_gap;

   // ==========================================================
   // Stop release pin crossing
   scmc_sync #(.W(1)) u_stop_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .pin_i(stop_release_i),
      .level_o(stop_rel_lvl)
   );

   // ==========================================================
   // Base timer source falling edge
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tap_prev_ff <= 1'b0;
      end else begin
         tap_prev_ff <= tbt_src_i[base_timer_clock_select_i];
      end
   end
   assign tap_fall = tap_prev_ff & ~tbt_src_i[base_timer_clock_select_i];

   // ==========================================================
   // Helpers
   function automatic logic is_lf_cpu(input scmc_pkg::scmc_mode_t m);
      is_lf_cpu = (m == scmc_pkg::slow_main_osc_on_mode) ||
                  (m == scmc_pkg::slow_main_osc_off_mode);
   endfunction : is_lf_cpu

   function automatic logic is_run(input scmc_pkg::scmc_mode_t m);
      is_run = (m == scmc_pkg::single_clock_run_mode) ||
               (m == scmc_pkg::dual_clock_run_mode) || is_lf_cpu(m);
   endfunction : is_run

   function automatic scmc_pkg::scmc_clk_ctrl_t decode(
      input scmc_pkg::scmc_mode_t m);
      scmc_pkg::scmc_clk_ctrl_t c;
      c = '0;
      case (m)
         scmc_pkg::single_clock_run_mode: begin
            c.main_osc_en = 1'b1;
            c.cpu_clk_en = 1'b1;
            c.periph_hf_en = 1'b1;
            c.tbt_clk_en = 1'b1;
         end
         scmc_pkg::dual_clock_run_mode: begin
            c.main_osc_en = 1'b1;
            c.sub_osc_en = 1'b1;
            c.cpu_clk_en = 1'b1;
            c.periph_hf_en = 1'b1;
            c.periph_lf_en = 1'b1;
            c.tbt_clk_en = 1'b1;
         end
         scmc_pkg::slow_main_osc_on_mode: begin
            c.main_osc_en = 1'b1;
            c.sub_osc_en = 1'b1;
            c.cpu_clk_en = 1'b1;
            c.cpu_clk_sel_lf = 1'b1;
            c.periph_hf_en = 1'b1;
            c.periph_lf_en = 1'b1;
            c.tbt_clk_en = 1'b1;
            c.tbt_clk_sel_lf = 1'b1;
         end
         scmc_pkg::slow_main_osc_off_mode: begin
            c.sub_osc_en = 1'b1;
            c.cpu_clk_en = 1'b1;
            c.cpu_clk_sel_lf = 1'b1;
            c.periph_lf_en = 1'b1;
            c.tbt_clk_en = 1'b1;
            c.tbt_clk_sel_lf = 1'b1;
         end
         scmc_pkg::cpu_halt_hf_mode: begin
            c.main_osc_en = 1'b1;
            c.periph_hf_en = 1'b1;
            c.tbt_clk_en = 1'b1;
         end
         scmc_pkg::cpu_halt_dual_mode, scmc_pkg::cpu_halt_lf_dual_mode: begin
            c.main_osc_en = 1'b1;
            c.sub_osc_en = 1'b1;
            c.periph_hf_en = 1'b1;
            c.periph_lf_en = 1'b1;
            c.tbt_clk_en = 1'b1;
            c.tbt_clk_sel_lf = (m == scmc_pkg::cpu_halt_lf_dual_mode);
         end
         scmc_pkg::cpu_halt_lf_mode: begin
            c.sub_osc_en = 1'b1;
            c.periph_lf_en = 1'b1;
            c.tbt_clk_en = 1'b1;
            c.tbt_clk_sel_lf = 1'b1;
         end
         scmc_pkg::deep_idle_hf_mode: begin
            c.main_osc_en = 1'b1;
            c.sub_osc_en = resume_ff == scmc_pkg::dual_clock_run_mode;
            c.tbt_clk_en = 1'b1;
         end
         scmc_pkg::deep_idle_lf_mode: begin
            c.sub_osc_en = 1'b1;
            c.main_osc_en = resume_ff == scmc_pkg::slow_main_osc_on_mode;
            c.tbt_clk_en = 1'b1;
            c.tbt_clk_sel_lf = 1'b1;
         end
         scmc_pkg::osc_stop_mode: begin
            c = '0;
         end
         default: begin
            c = '0;
         end
      endcase
      decode = c;
   endfunction : decode

   // ==========================================================
   // Next mode
   always_comb begin
      nxt_mode = mode_ff;
      wake = 1'b0;
      case (mode_ff)
         scmc_pkg::single_clock_run_mode,
         scmc_pkg::dual_clock_run_mode,
         scmc_pkg::slow_main_osc_on_mode,
         scmc_pkg::slow_main_osc_off_mode: begin
            if (stop_req_i) begin
               nxt_mode = scmc_pkg::osc_stop_mode;
            end else if (ctl_wr_i && ctl_data_i[`SCMC_CTL_TIMING_GEN_HALT_BIT]) begin
               nxt_mode = is_lf_cpu(mode_ff) ? scmc_pkg::deep_idle_lf_mode
                          : scmc_pkg::deep_idle_hf_mode;
            end else if (ctl_wr_i && ctl_data_i[`SCMC_CTL_IDLE]) begin
               case (mode_ff)
                  scmc_pkg::dual_clock_run_mode:
                     nxt_mode = scmc_pkg::cpu_halt_dual_mode;
                  scmc_pkg::slow_main_osc_on_mode:
                     nxt_mode = scmc_pkg::cpu_halt_lf_dual_mode;
                  scmc_pkg::slow_main_osc_off_mode:
                     nxt_mode = scmc_pkg::cpu_halt_lf_mode;
                  default:
                     nxt_mode = scmc_pkg::cpu_halt_hf_mode;
               endcase
            end else if (ctl_wr_i) begin
               // Slow needs the sub oscillator; main off only in slow
               if (ctl_data_i[`SCMC_CTL_SYSCK] &&
                   ctl_data_i[`SCMC_CTL_XTEN]) begin
                  nxt_mode = ctl_data_i[`SCMC_CTL_XEN]
                     ? scmc_pkg::slow_main_osc_on_mode
                     : scmc_pkg::slow_main_osc_off_mode;
               end else if (!ctl_data_i[`SCMC_CTL_SYSCK]) begin
                  nxt_mode = ctl_data_i[`SCMC_CTL_XTEN]
                     ? scmc_pkg::dual_clock_run_mode
                     : scmc_pkg::single_clock_run_mode;
               end
            end
         end
         scmc_pkg::cpu_halt_hf_mode, scmc_pkg::cpu_halt_dual_mode,
         scmc_pkg::cpu_halt_lf_mode, scmc_pkg::cpu_halt_lf_dual_mode: begin
            if (irq_req_i) begin
               wake = 1'b1;
               nxt_mode = resume_ff;
            end
         end
         scmc_pkg::deep_idle_hf_mode, scmc_pkg::deep_idle_lf_mode: begin
            if (tap_fall) begin
               wake = 1'b1;
               nxt_mode = resume_ff;
            end
         end
         scmc_pkg::osc_stop_mode: begin
            if (stop_rel_lvl) begin
               wake = 1'b1;
               nxt_mode = resume_ff;
            end
         end
         default: begin
            nxt_mode = scmc_pkg::single_clock_run_mode;
         end
      endcase
   end

   // ==========================================================
   // Mode register and run mode to return to
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mode_ff <= scmc_pkg::single_clock_run_mode;
         resume_ff <= scmc_pkg::single_clock_run_mode;
      end else begin
         mode_ff <= nxt_mode;
         if (is_run(mode_ff)) begin
            resume_ff <= mode_ff;
         end
      end
   end

   // ==========================================================
   // Break before make on a CPU source change avoids a runt pulse
   always_comb begin
      nxt_gap = (gap_ff != '0) ? gap_ff - 1'b1 : gap_ff;
      if (is_lf_cpu(nxt_mode) != is_lf_cpu(mode_ff) &&
          is_run(nxt_mode)) begin
         nxt_gap = `SCMC_GAP_W'(`SCMC_GAP_CYC);
      end
      nxt_ctrl = decode(nxt_mode);
      if (nxt_gap != '0) begin
         nxt_ctrl.cpu_clk_en = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         gap_ff <= '0;
         clk_ctrl_o <= '0;
         mode_o <= scmc_pkg::single_clock_run_mode;
         wake_o <= 1'b0;
      end else begin
         gap_ff <= nxt_gap;
         clk_ctrl_o <= nxt_ctrl;
         mode_o <= nxt_mode;
         wake_o <= wake;
      end
   end
endmodule : scmc_top

// ===== sim/scmc_top_props.sv
// Port assertions of the standby and clock mode controller
`timescale 1ns/100ps
`include "scmc_cfg.svh"
module scmc_top_props (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ctl_wr_i,
   input wire logic [`SCMC_CTL_W-1:0] ctl_data_i,
   input wire logic stop_req_i,
   input wire logic stop_release_i,
   input wire logic irq_req_i,
   input wire logic [`SCMC_TBT_SEL_W-1:0] base_timer_clock_select_i,
   input wire logic [`SCMC_TBT_TAPS-1:0] tbt_src_i,
   input scmc_pkg::scmc_mode_t mode_o,
   input scmc_pkg::scmc_clk_ctrl_t clk_ctrl_o,
   input wire logic wake_o
);
   // =======================================================
   // Mode to clock enable relations, wake-ups and mode changes
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic run1;
   logic halt1;
   assign run1 = mode_o == scmc_pkg::single_clock_run_mode;
   assign halt1 = mode_o == scmc_pkg::cpu_halt_hf_mode;
   property p_stop_off;
      mode_o == scmc_pkg::osc_stop_mode |-> clk_ctrl_o == 8'h00;
   endproperty
   a_stop_off: assert property (p_stop_off)
      else $error("clock alive in stop mode");
   // Select checked only once the gap has ended
   property p_slow_main_osc_off_mode;
      mode_o == scmc_pkg::slow_main_osc_off_mode |-> !clk_ctrl_o[7] &&
         clk_ctrl_o[6] && (!clk_ctrl_o[5] || clk_ctrl_o[4]);
   endproperty
   a_slow_main_osc_off_mode: assert property (p_slow_main_osc_off_mode)
      else $error("slow mode one clocks wrong");
   property p_slow_main_osc_on_mode;
      mode_o == scmc_pkg::slow_main_osc_on_mode |-> clk_ctrl_o[7] &&
         clk_ctrl_o[6] && (!clk_ctrl_o[5] || clk_ctrl_o[4]);
   endproperty
   a_slow_main_osc_on_mode: assert property (p_slow_main_osc_on_mode)
      else $error("slow mode two clocks wrong");
   property p_deep_hf;
      mode_o == scmc_pkg::deep_idle_hf_mode |-> (clk_ctrl_o & 8'h2f) == 8'h02;
   endproperty
   a_deep_hf: assert property (p_deep_hf)
      else $error("deep idle high clocks wrong");
   property p_deep_lf;
      mode_o == scmc_pkg::deep_idle_lf_mode |-> (clk_ctrl_o & 8'h2f) == 8'h03;
   endproperty
   a_deep_lf: assert property (p_deep_lf)
      else $error("deep idle low clocks wrong");
   property p_halt1;
      halt1 |-> (clk_ctrl_o & 8'h28) == 8'h08;
   endproperty
   a_halt1: assert property (p_halt1)
      else $error("idle high clocks wrong");
   property p_irq_wake;
      halt1 && irq_req_i |=> run1 && wake_o;
   endproperty
   a_irq_wake: assert property (p_irq_wake)
      else $error("interrupt did not end idle");
   property p_idle_wr;
      run1 && ctl_wr_i && ctl_data_i[1:0] == 2'b10 && !stop_req_i |=> halt1;
   endproperty
   a_idle_wr: assert property (p_idle_wr)
      else $error("idle write not taken");
   property p_halt_wr;
      run1 && ctl_wr_i && ctl_data_i[0] && !stop_req_i
         |=> mode_o == scmc_pkg::deep_idle_hf_mode;
   endproperty
   a_halt_wr: assert property (p_halt_wr)
      else $error("halt write not taken");
   // Synchroniser and filter need several samples
   property p_release;
      stop_release_i [*8] |-> mode_o != scmc_pkg::osc_stop_mode;
   endproperty
   a_release: assert property (p_release)
      else $error("release level did not end stop");
   property p_reset;
      $fell(reset_i) |=> run1 && clk_ctrl_o == 8'haa;
   endproperty
   a_reset: assert property (p_reset)
      else $error("wrong state after reset");
   c_stop: cover property (mode_o == scmc_pkg::osc_stop_mode);
   c_deep: cover property (mode_o == scmc_pkg::deep_idle_lf_mode);
   c_wake: cover property (wake_o);
endmodule : scmc_top_props
bind scmc_top scmc_top_props i_scmc_top_props (.clk_i(clk_i),
   .reset_i(reset_i), .ctl_wr_i(ctl_wr_i), .ctl_data_i(ctl_data_i),
   .stop_req_i(stop_req_i), .stop_release_i(stop_release_i),
   .irq_req_i(irq_req_i), .tbt_src_i(tbt_src_i),
   .base_timer_clock_select_i(base_timer_clock_select_i),
   .mode_o(mode_o), .clk_ctrl_o(clk_ctrl_o), .wake_o(wake_o));

// ===== sim/scmc_far_side.sv
// Far side model: timer source taps and wake-up pins
`timescale 1ns/100ps
module scmc_far_side (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic irq_cmd_i,
   input wire logic release_cmd_i,
   output logic [7:0] tbt_src_o,
   output logic stop_release_o,
   output logic irq_req_o
);
   // =======================================================
   // Free running source, each tap one stage slower
   logic [8:0] div_ff;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_ff <= 9'h000;
         stop_release_o <= 1'b0;
         irq_req_o <= 1'b0;
      end else begin
         div_ff <= div_ff + 9'h001;
         stop_release_o <= release_cmd_i;
         irq_req_o <= irq_cmd_i;
      end
   end
   assign tbt_src_o = div_ff[8:1];
endmodule : scmc_far_side

// ===== sim/standby_clock_mode_control_tb_top.sv
// Self-checking bench of the standby and clock mode controller
`timescale 1ns/100ps
module standby_clock_mode_control_tb_top;
   // =======================================================
   // Signals, clock and instances
   logic clk_i = 1'b0, reset_i = 1'b1, ctl_wr_i = 1'b0, stop_req_i = 1'b0;
   logic irq_cmd = 1'b0, rel_cmd = 1'b0, stop_release_i, irq_req_i, wake_o;
   logic [4:0] ctl_data_i = 5'h00;
   logic [2:0] sel = 3'h0;
   logic [7:0] tbt_src_i;
   scmc_pkg::scmc_mode_t mode_o;
   scmc_pkg::scmc_clk_ctrl_t clk_ctrl_o;
   int miscompares = 0, check_count = 0;
   always #5 clk_i = ~clk_i;
   scmc_top i_scmc_top (.clk_i(clk_i), .reset_i(reset_i),
      .ctl_wr_i(ctl_wr_i), .ctl_data_i(ctl_data_i), .stop_req_i(stop_req_i),
      .stop_release_i(stop_release_i), .irq_req_i(irq_req_i),
      .base_timer_clock_select_i(sel), .tbt_src_i(tbt_src_i),
      .mode_o(mode_o), .clk_ctrl_o(clk_ctrl_o), .wake_o(wake_o));
   scmc_far_side i_scmc_far_side (.clk_i(clk_i), .reset_i(reset_i),
      .irq_cmd_i(irq_cmd), .release_cmd_i(rel_cmd), .tbt_src_o(tbt_src_i),
      .stop_release_o(stop_release_i), .irq_req_o(irq_req_i));
   // =======================================================
   // Expectations and checks
   // Main, sub and cpu enables in enum order
   function automatic logic [2:0] exp_osc(input scmc_pkg::scmc_mode_t m);
      logic [2:0] t [11] = '{3'h5, 3'h7, 3'h7, 3'h3, 3'h4, 3'h6, 3'h4,
         3'h2, 3'h6, 3'h2, 3'h0};
      return t[m];
   endfunction : exp_osc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   // Deep idle may wake within a few cycles, so n is 0
   task automatic go(input logic [4:0] d, input scmc_pkg::scmc_mode_t m,
      input int n);
      @(negedge clk_i) ctl_wr_i = 1'b1;
      ctl_data_i = d;
      @(negedge clk_i) ctl_wr_i = 1'b0;
      repeat (n) @(negedge clk_i);
      chk(8'(mode_o), 8'(m));
      chk(8'(clk_ctrl_o[7:5]), 8'(exp_osc(m)));
   endtask : go
   task automatic wake(input logic irq, input scmc_pkg::scmc_mode_t m);
      irq_cmd = irq;
      for (int i = 0; i < 600 && mode_o !== m; i++) @(negedge clk_i);
      chk(8'(mode_o), 8'(m));
      chk({7'h00, wake_o}, 8'h01);
      irq_cmd = 1'b0;
   endtask : wake
   task automatic stop_cycle(input scmc_pkg::scmc_mode_t m);
      @(negedge clk_i) stop_req_i = 1'b1;
      @(negedge clk_i) stop_req_i = 1'b0;
      repeat (20) @(negedge clk_i);
      chk(8'(mode_o), 8'(scmc_pkg::osc_stop_mode));
      chk(8'(clk_ctrl_o), 8'h00);
      // Release held past the wake so the long-level check is reached
      rel_cmd = 1'b1;
      wake(1'b0, m);
      repeat (10) @(negedge clk_i);
      rel_cmd = 1'b0;
      repeat (10) @(negedge clk_i);
   endtask : stop_cycle
   // =======================================================
   // Main sequence and watchdog
   initial begin
      int r;
      r = $urandom(60523);
      repeat (6) @(posedge clk_i);
      @(negedge clk_i) reset_i = 1'b0;
      @(negedge clk_i);
      chk(8'(mode_o), 8'(scmc_pkg::single_clock_run_mode));
      chk(8'(clk_ctrl_o), 8'haa);
      for (int i = 0; i < 16; i++) begin
         sel = 3'(i >> 1);
         if (i % 2) begin
            go(5'h02, scmc_pkg::cpu_halt_hf_mode, 4);
            repeat ($urandom % 8) @(negedge clk_i);
            wake(1'b1, scmc_pkg::single_clock_run_mode);
         end else begin
            // Halt wins over any other bit
            go(5'($urandom) | 5'h01, scmc_pkg::deep_idle_hf_mode, 0);
            wake(1'b0, scmc_pkg::single_clock_run_mode);
         end
      end
      stop_cycle(scmc_pkg::single_clock_run_mode);
      go(5'h18, scmc_pkg::dual_clock_run_mode, 4);
      go(5'h1a, scmc_pkg::cpu_halt_dual_mode, 4);
      wake(1'b1, scmc_pkg::dual_clock_run_mode);
      go(5'h1c, scmc_pkg::slow_main_osc_on_mode, 4);
      go(5'h1e, scmc_pkg::cpu_halt_lf_dual_mode, 4);
      wake(1'b1, scmc_pkg::slow_main_osc_on_mode);
      go(5'h0c, scmc_pkg::slow_main_osc_off_mode, 4);
      go(5'h14, scmc_pkg::slow_main_osc_off_mode, 4);
      go(5'h0e, scmc_pkg::cpu_halt_lf_mode, 4);
      wake(1'b1, scmc_pkg::slow_main_osc_off_mode);
      sel = 3'($urandom % 3);
      go(5'h0d, scmc_pkg::deep_idle_lf_mode, 0);
      wake(1'b0, scmc_pkg::slow_main_osc_off_mode);
      stop_cycle(scmc_pkg::slow_main_osc_off_mode);
      go(5'h1c, scmc_pkg::slow_main_osc_on_mode, 4);
      go(5'h10, scmc_pkg::single_clock_run_mode, 4);
      report_and_stop();
   end
   // Far above the longest legal run of deep idle waits
   initial begin
      #200000;
      miscompares++;
      report_and_stop();
   end
endmodule : standby_clock_mode_control_tb_top
